// ===== pkg/hbs_pkg.sv
package hbs_pkg;

  // Link command codes
  localparam logic [7:0] HBS_CMD_MONITOR   = 8'h30;
  localparam logic [7:0] HBS_CMD_SERVO_ON  = 8'h31;
  localparam logic [7:0] HBS_CMD_SERVO_OFF = 8'h32;
  localparam logic [7:0] HBS_CMD_PATH_STEP = 8'h34;
  localparam logic [7:0] HBS_CMD_POSITION  = 8'h35;
  localparam logic [7:0] HBS_CMD_CONST_SPD = 8'h36;

  // Field positions in the monitor and status words
  localparam int HBS_IO_BLOCK_BIT = 7;
  localparam int HBS_ST_MRDY_BIT  = 12;
  localparam int HBS_ST_SVON_BIT  = 13;
  localparam int HBS_ST_CMD_LSB   = 0;

  // Stop method setting codes
  localparam logic [3:0] HBS_STOP_BRAKE_HOLD = 4'h0;
  localparam logic [3:0] HBS_STOP_BRAKE_FREE = 4'h1;

  // Timing
  localparam int unsigned HBS_CLK_HZ       = 20_000_000;
  localparam int unsigned HBS_STOP_TIME_MS = 100;
  localparam int unsigned HBS_STOP_CYCLES  = HBS_STOP_TIME_MS * (HBS_CLK_HZ / 1000);

  // Host register offsets
  localparam logic [7:0] HBS_REG_CTRL   = 8'h00;
  localparam logic [7:0] HBS_REG_CMD    = 8'h04;
  localparam logic [7:0] HBS_REG_STATUS = 8'h08;
  localparam logic [7:0] HBS_REG_IRQ_ST = 8'h0c;
  localparam logic [7:0] HBS_REG_IRQ_MK = 8'h10;
  localparam logic [7:0] HBS_REG_POS    = 8'h14;

  // Host control and interrupt bits
  localparam int HBS_CTRL_GO     = 0;
  localparam int HBS_CTRL_RETURN = 1;
  localparam int HBS_IRQ_W       = 5;
  localparam int HBS_IRQ_BLOCK   = 0;
  localparam int HBS_IRQ_RECOVER = 1;
  localparam int HBS_IRQ_RESUMED = 2;
  localparam int HBS_IRQ_WARN    = 3;
  localparam int HBS_IRQ_REFUSED = 4;

  typedef enum logic [2:0] {
    HBS_D_OFF   = 3'b001,
    HBS_D_ON    = 3'b010,
    HBS_D_BLOCK = 3'b100
  } hbs_dstate_t;

  typedef enum logic [7:0] {
    HBS_H_RUN      = 8'b0000_0001,
    HBS_H_OFF_CMD  = 8'b0000_0010,
    HBS_H_MON_CMD  = 8'b0000_0100,
    HBS_H_WAIT_CLR = 8'b0000_1000,
    HBS_H_WAIT_RDY = 8'b0001_0000,
    HBS_H_DECIDE   = 8'b0010_0000,
    HBS_H_ON_CMD   = 8'b0100_0000,
    HBS_H_WAIT_ON  = 8'b1000_0000
  } hbs_hstate_t;

  // One of the four motion commands that a block interrupts
  function automatic logic hbs_is_motion(input logic [7:0] code);
    hbs_is_motion = (code == HBS_CMD_SERVO_ON) || (code == HBS_CMD_PATH_STEP) ||
                    (code == HBS_CMD_POSITION) || (code == HBS_CMD_CONST_SPD);
  endfunction

endpackage

// ===== pkg/hbs_link_if.sv
`timescale 1ns/1ns
interface hbs_link_if;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [31:0] servo_io_monitor_word;
  logic [31:0] servo_status_word;
  logic [31:0] feedback_coordinate_position;
  logic        cmd_warning;

  modport drive (
    input  cmd_valid,
    input  cmd_code,
    output servo_io_monitor_word,
    output servo_status_word,
    output feedback_coordinate_position,
    output cmd_warning
  );

  modport host (
    output cmd_valid,
    output cmd_code,
    input  servo_io_monitor_word,
    input  servo_status_word,
    input  feedback_coordinate_position,
    input  cmd_warning
  );
endinterface

// ===== design/hbs_sync.sv
`timescale 1ns/1ns
module hbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ===== design/hbs_drive_end.sv
// What this block does
// - Cut motor current when either block input opens
// - Unshorted inputs hold block, refuse motor drive
// - Block entry raises no alarm, status only
// - Block flag bit 7 rises on block
// - Block clears power-ready bit 12, energized 13
// - Host sends monitor-only if blocked servo-off
// - Blocked while on: stop per stop method
// - Host sends servo-off, monitor-only, then waits
// - Warn when block interrupts a motion command
// - Servo-off or non-motion command clears warning
// - Host waits flag low, then power ready
// - Host reads position, chooses continue or return
// - Host re-energizes before moving the axis
// - Servo-on uses command code 31 hex
`timescale 1ns/1ns
module hbs_drive_end
  import hbs_pkg::*;
#(
  parameter int unsigned STOP_CYCLES = HBS_STOP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  hbs_link_if.drive        link,
  input  wire logic        block_input_first,
  input  wire logic        block_input_second,
  input  wire logic        main_power_ok,
  input  wire logic [3:0]  stop_method_setting,
  input  wire logic [31:0] feedback_coordinate_position,
  output logic             motor_current_en,
  output logic             dynamic_brake_on,
  output logic             hardwired_current_block
);
  // Stop timer wide enough for the full count
  localparam int CW = $clog2(STOP_CYCLES + 1);

  hbs_dstate_t state;
  hbs_dstate_t next_state;
  logic [6:0]  pins_sync;
  logic        in_first;
  logic        in_second;
  logic        power_ok;
  logic [3:0]  stop_method;
  logic [7:0]  active_cmd;
  logic [7:0]  next_active_cmd;
  logic        warn;
  logic        next_warn;
  logic        brake;
  logic        next_brake;
  logic [CW-1:0] brake_cnt;
  logic [CW-1:0] next_brake_cnt;
  logic        block_now;
  logic        block_entry;
  logic        cmd_take;
  logic        cmd_is_on;
  logic        cmd_is_off;
  logic        cmd_clears;
  logic        stop_coast;
  logic        stop_free;
  logic [31:0] next_io_word;
  logic [31:0] next_status_word;

  // Pins and the stop setting come from outside the clock domain
  hbs_sync #(
    .W (7)
  ) u_pin_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({block_input_first, block_input_second, main_power_ok, stop_method_setting}),
    .q    (pins_sync)
  );

  assign in_first    = pins_sync[6];
  assign in_second   = pins_sync[5];
  assign power_ok    = pins_sync[4];
  assign stop_method = pins_sync[3:0];

  // Block decode: any open contact blocks, only both closed release
  assign block_now   = ~(in_first & in_second);
  assign block_entry = block_now & (state != HBS_D_BLOCK);

  // Command decode
  assign cmd_take   = link.cmd_valid;
  assign cmd_is_on  = cmd_take & (link.cmd_code == HBS_CMD_SERVO_ON);
  assign cmd_is_off = cmd_take & (link.cmd_code == HBS_CMD_SERVO_OFF);
  assign cmd_clears = cmd_take & ~hbs_is_motion(link.cmd_code);

  // Stop method decode
  assign stop_free  = (stop_method == HBS_STOP_BRAKE_FREE);
  assign stop_coast = (stop_method != HBS_STOP_BRAKE_HOLD) & ~stop_free;

  // Servo state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      HBS_D_OFF: begin
        // Servo-on is taken only with main power present
        if (block_now) begin
          next_state = HBS_D_BLOCK;
        end else if (cmd_is_on && power_ok) begin
          next_state = HBS_D_ON;
        end
      end
      HBS_D_ON: begin
        if (block_now) begin
          next_state = HBS_D_BLOCK;
        end else if (cmd_is_off || !power_ok) begin
          next_state = HBS_D_OFF;
        end
      end
      HBS_D_BLOCK: begin
        // Servo-on refused here; release returns to servo off
        if (!block_now) begin
          next_state = HBS_D_OFF;
        end
      end
      default: next_state = HBS_D_OFF;
    endcase
  end

  // Last command taken, seen as the one executing
  assign next_active_cmd = cmd_take ? link.cmd_code : active_cmd;

  // Command warning: set on block entry during motion, set wins
  always_comb begin
    next_warn = warn;
    // Clear first so that a set in the same cycle wins
    if (cmd_clears) begin
      next_warn = 1'b0;
    end
    if (block_entry && hbs_is_motion(active_cmd)) begin
      next_warn = 1'b1;
    end
  end

  // Stop handling when the block hits an energized servo
  always_comb begin
    next_brake     = brake;
    next_brake_cnt = brake_cnt;
    // Hold and free methods brake at entry, any other coasts
    if (state == HBS_D_ON && block_now) begin
      next_brake     = ~stop_coast;
      next_brake_cnt = CW'(STOP_CYCLES);
    end else if (state == HBS_D_BLOCK && block_now) begin
      // Free method lets go when the timer runs out
      if (stop_free && brake_cnt != '0) begin
        next_brake_cnt = brake_cnt - 1'b1;
        if (brake_cnt == CW'(1)) begin
          next_brake = 1'b0;
        end
      end
    end else begin
      next_brake     = 1'b0;
      next_brake_cnt = '0;
    end
  end

  // Monitor and status words; no alarm field exists
  // Built from next values so words switch with the state
  always_comb begin
    next_io_word                           = 32'h0000_0000;
    next_io_word[HBS_IO_BLOCK_BIT]         = (next_state == HBS_D_BLOCK);
    next_status_word                       = 32'h0000_0000;
    next_status_word[HBS_ST_CMD_LSB +: 8]  = next_active_cmd;
    next_status_word[HBS_ST_MRDY_BIT]      = power_ok & (next_state != HBS_D_BLOCK);
    next_status_word[HBS_ST_SVON_BIT]      = (next_state == HBS_D_ON);
  end

  // State registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state      <= HBS_D_OFF;
      active_cmd <= HBS_CMD_MONITOR;
      warn       <= 1'b0;
      brake      <= 1'b0;
      brake_cnt  <= '0;
    end else begin
      state      <= next_state;
      active_cmd <= next_active_cmd;
      warn       <= next_warn;
      brake      <= next_brake;
      brake_cnt  <= next_brake_cnt;
    end
  end

  // Registered outputs toward the link and the power stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.servo_io_monitor_word        <= 32'h0000_0000;
      link.servo_status_word            <= 32'h0000_0000;
      link.feedback_coordinate_position <= 32'h0000_0000;
      link.cmd_warning                  <= 1'b0;
      motor_current_en                  <= 1'b0;
      dynamic_brake_on                  <= 1'b0;
      hardwired_current_block           <= 1'b1;
    end else begin
      link.servo_io_monitor_word        <= next_io_word;
      link.servo_status_word            <= next_status_word;
      link.feedback_coordinate_position <= feedback_coordinate_position;
      link.cmd_warning                  <= next_warn;
      motor_current_en                  <= (next_state == HBS_D_ON);
      dynamic_brake_on                  <= next_brake;
      hardwired_current_block           <= (next_state == HBS_D_BLOCK);
    end
  end
endmodule

// ===== design/hbs_host_end.sv
`timescale 1ns/1ns
module hbs_host_end
  import hbs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  hbs_link_if.host         link,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  output logic             axis_move_ok
);
  hbs_hstate_t state;
  hbs_hstate_t next_state;
  logic                flag_q;
  logic                svon_q;
  logic                warn_q;
  logic                plan_return;
  logic [31:0]         pos_latch;
  logic [HBS_IRQ_W-1:0] irq_st;
  logic [HBS_IRQ_W-1:0] irq_mk;
  logic [HBS_IRQ_W-1:0] events;
  logic [HBS_IRQ_W-1:0] next_irq_st;
  logic                next_cmd_valid;
  logic [7:0]          next_cmd_code;
  logic [31:0]         next_rdata;
  logic                flag;
  logic                mrdy;
  logic                svon;
  logic                flag_rise;
  logic                wr_ctrl;
  logic                wr_cmd;
  logic                go;
  logic                sw_cmd_ok;
  logic                latch_pos;
  logic [31:0]         status_rd;

  // Link field decode
  assign flag      = link.servo_io_monitor_word[HBS_IO_BLOCK_BIT];
  assign mrdy      = link.servo_status_word[HBS_ST_MRDY_BIT];
  assign svon      = link.servo_status_word[HBS_ST_SVON_BIT];
  assign flag_rise = flag & ~flag_q;

  // Register write decode
  assign wr_ctrl   = wr & (addr == HBS_REG_CTRL);
  assign wr_cmd    = wr & (addr == HBS_REG_CMD);
  assign go        = wr_ctrl & wdata[HBS_CTRL_GO] & (state == HBS_H_DECIDE);
  assign sw_cmd_ok = wr_cmd & (state == HBS_H_RUN) & ~flag_rise;
  assign latch_pos = (state == HBS_H_WAIT_RDY) & mrdy & ~flag;

  // Block handling and recovery sequence
  always_comb begin
    next_state = state;
    unique case (state)
      HBS_H_RUN:      next_state = state;
      HBS_H_OFF_CMD:  next_state = HBS_H_MON_CMD;
      HBS_H_MON_CMD:  next_state = HBS_H_WAIT_CLR;
      HBS_H_WAIT_CLR: if (!flag) next_state = HBS_H_WAIT_RDY;
      HBS_H_WAIT_RDY: if (latch_pos) next_state = HBS_H_DECIDE;
      HBS_H_DECIDE:   if (go) next_state = HBS_H_ON_CMD;
      HBS_H_ON_CMD:   next_state = HBS_H_WAIT_ON;
      HBS_H_WAIT_ON:  if (svon) next_state = HBS_H_RUN;
      default:        next_state = HBS_H_RUN;
    endcase
    // A fresh block restarts the sequence from any state
    if (flag_rise) begin
      next_state = svon_q ? HBS_H_OFF_CMD : HBS_H_MON_CMD;
    end
  end

  // Command issue toward the drive
  always_comb begin
    next_cmd_valid = 1'b0;
    next_cmd_code  = HBS_CMD_MONITOR;
    if (state == HBS_H_OFF_CMD) begin
      next_cmd_valid = 1'b1;
      next_cmd_code  = HBS_CMD_SERVO_OFF;
    end else if (state == HBS_H_MON_CMD) begin
      next_cmd_valid = 1'b1;
      next_cmd_code  = HBS_CMD_MONITOR;
    end else if (state == HBS_H_ON_CMD) begin
      next_cmd_valid = 1'b1;
      next_cmd_code  = HBS_CMD_SERVO_ON;
    end else if (sw_cmd_ok) begin
      next_cmd_valid = 1'b1;
      next_cmd_code  = wdata[7:0];
    end
  end

  // Interrupt events; set wins over write-one-to-clear
  assign events[HBS_IRQ_BLOCK]   = flag_rise;
  assign events[HBS_IRQ_RECOVER] = latch_pos;
  assign events[HBS_IRQ_RESUMED] = (state == HBS_H_WAIT_ON) & svon & ~flag_rise;
  assign events[HBS_IRQ_WARN]    = link.cmd_warning & ~warn_q;
  assign events[HBS_IRQ_REFUSED] = wr_cmd & ~sw_cmd_ok;
  assign next_irq_st = (irq_st & ~((wr && addr == HBS_REG_IRQ_ST) ?
                        wdata[HBS_IRQ_W-1:0] : {HBS_IRQ_W{1'b0}})) | events;

  // Read mux
  assign status_rd = {16'h0000, 8'(state), 3'b000, axis_move_ok, warn_q, svon, mrdy, flag};
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        HBS_REG_CTRL:   next_rdata = {30'h0, plan_return, (state == HBS_H_DECIDE)};
        HBS_REG_STATUS: next_rdata = status_rd;
        HBS_REG_IRQ_ST: next_rdata = {27'h0, irq_st};
        HBS_REG_IRQ_MK: next_rdata = {27'h0, irq_mk};
        HBS_REG_POS:    next_rdata = pos_latch;
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // State and history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state  <= HBS_H_RUN;
      flag_q <= 1'b0;
      svon_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      state  <= next_state;
      flag_q <= flag;
      svon_q <= svon;
      warn_q <= link.cmd_warning;
    end
  end

  // Software registers, recovery data and link outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      plan_return    <= 1'b0;
      pos_latch      <= 32'h0000_0000;
      irq_st         <= '0;
      irq_mk         <= '0;
      link.cmd_valid <= 1'b0;
      link.cmd_code  <= HBS_CMD_MONITOR;
      rdata          <= 32'h0000_0000;
      irq            <= 1'b0;
      axis_move_ok   <= 1'b1;
    end else begin
      if (go) plan_return <= wdata[HBS_CTRL_RETURN];
      if (latch_pos) pos_latch <= link.feedback_coordinate_position;
      if (wr && addr == HBS_REG_IRQ_MK) irq_mk <= wdata[HBS_IRQ_W-1:0];
      irq_st         <= next_irq_st;
      link.cmd_valid <= next_cmd_valid;
      link.cmd_code  <= next_cmd_code;
      rdata          <= next_rdata;
      irq            <= |(next_irq_st & irq_mk);
      axis_move_ok   <= (next_state == HBS_H_RUN);
    end
  end
endmodule

// ===== testbench/hbs_link_chk.sv
`timescale 1ns/1ns
module hbs_link_chk
  import hbs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [31:0] servo_io_monitor_word,
  input wire logic [31:0] servo_status_word,
  input wire logic [31:0] feedback_coordinate_position,
  input wire logic        cmd_warning
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Link steps of the block sequence
  sequence s_flag_rise;
    $rose(servo_io_monitor_word[HBS_IO_BLOCK_BIT]);
  endsequence
  sequence s_off_then_mon;
    (cmd_valid && cmd_code == HBS_CMD_SERVO_OFF) ##1 (cmd_valid && cmd_code == HBS_CMD_MONITOR);
  endsequence

  property p_entry_clears_ready;
    s_flag_rise |-> !servo_status_word[HBS_ST_MRDY_BIT] && !servo_status_word[HBS_ST_SVON_BIT];
  endproperty
  property p_block_keeps_off;
    servo_io_monitor_word[HBS_IO_BLOCK_BIT] |-> !servo_status_word[HBS_ST_SVON_BIT];
  endproperty
  property p_io_quiet;
    servo_io_monitor_word[31:8] == 24'h0 && servo_io_monitor_word[6:0] == 7'h0;
  endproperty
  property p_warn_on_block;
    s_flag_rise ##0 (!$past(cmd_valid) &&
      ($past(servo_status_word[7:0]) inside {8'h31, 8'h34, 8'h35, 8'h36})) |-> cmd_warning;
  endproperty
  property p_warn_needs_block;
    $rose(cmd_warning) |-> $rose(servo_io_monitor_word[HBS_IO_BLOCK_BIT]);
  endproperty
  property p_warn_clear;
    cmd_warning && servo_io_monitor_word[HBS_IO_BLOCK_BIT] && cmd_valid &&
      !(cmd_code inside {8'h31, 8'h34, 8'h35, 8'h36}) |=> !cmd_warning;
  endproperty
  property p_seq_on;
    s_flag_rise ##0 $past(servo_status_word[HBS_ST_SVON_BIT]) |-> ##2 s_off_then_mon;
  endproperty
  property p_seq_off;
    s_flag_rise ##0 !$past(servo_status_word[HBS_ST_SVON_BIT])
      |-> ##[1:2] (cmd_valid && cmd_code == HBS_CMD_MONITOR);
  endproperty
  property p_svon_by_cmd;
    $rose(servo_status_word[HBS_ST_SVON_BIT])
      |-> $past(cmd_valid) && $past(cmd_code) == HBS_CMD_SERVO_ON;
  endproperty

  a_entry_clears_ready: assert property (p_entry_clears_ready)
    else $error("ready bits not cleared on block entry");
  a_block_keeps_off: assert property (p_block_keeps_off)
    else $error("servo energized while blocked");
  a_io_quiet: assert property (p_io_quiet)
    else $error("unexpected bits in monitor word");
  a_warn_on_block: assert property (p_warn_on_block)
    else $error("no warning when motion interrupted");
  a_warn_needs_block: assert property (p_warn_needs_block)
    else $error("warning rose without block entry");
  a_warn_clear: assert property (p_warn_clear)
    else $error("warning not cleared by non-motion command");
  a_seq_on: assert property (p_seq_on)
    else $error("host did not send servo-off then monitor");
  a_seq_off: assert property (p_seq_off)
    else $error("host did not send monitor command");
  a_svon_by_cmd: assert property (p_svon_by_cmd)
    else $error("servo energized without servo-on command");
endmodule

// ===== testbench/hardwired_block_status_sequencer_bench.sv
`timescale 1ns/1ns
module hardwired_block_status_sequencer_bench;
  import hbs_pkg::*;
  typedef struct {logic [7:0] code; logic [3:0] meth; logic [1:0] opens; logic warn;} hbs_row_t;
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        in1  = 1'b1;
  logic        in2  = 1'b1;
  logic        pwr  = 1'b1;
  logic [3:0]  meth = 4'h0;
  logic [31:0] pos  = 32'h0;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        irq, move_ok, cur_en, brake, blk;
  logic [31:0] d;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  hbs_row_t    rows[5] = '{'{8'h31, 4'h0, 2'b01, 1'b1}, '{8'h34, 4'h1, 2'b10, 1'b1},
                           '{8'h35, 4'h2, 2'b11, 1'b1}, '{8'h36, 4'h0, 2'b11, 1'b1},
                           '{8'h32, 4'h0, 2'b01, 1'b0}};

  always #25 clk = ~clk;

  hbs_link_if link();
  hbs_drive_end #(.STOP_CYCLES(8)) hbs_drive_end_inst (.clk(clk), .rstn(rstn), .link(link),
    .block_input_first(in1), .block_input_second(in2), .main_power_ok(pwr),
    .stop_method_setting(meth), .feedback_coordinate_position(pos),
    .motor_current_en(cur_en), .dynamic_brake_on(brake), .hardwired_current_block(blk));
  hbs_host_end hbs_host_end_inst (.clk(clk), .rstn(rstn), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .axis_move_ok(move_ok));
  hbs_link_chk hbs_link_chk_inst (.clk(clk), .rstn(rstn), .cmd_valid(link.cmd_valid),
    .cmd_code(link.cmd_code), .servo_io_monitor_word(link.servo_io_monitor_word),
    .servo_status_word(link.servo_status_word),
    .feedback_coordinate_position(link.feedback_coordinate_position),
    .cmd_warning(link.cmd_warning));

  // Compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Register port cycles
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  // Bounded waits
  task wait_flag(input logic v);
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      if (link.servo_io_monitor_word[HBS_IO_BLOCK_BIT] === v) break;
    end
    check(link.servo_io_monitor_word[HBS_IO_BLOCK_BIT], v);
  endtask
  task wait_st(input logic [31:0] m, input logic [31:0] v);
    for (int k = 0; k < 100; k++) begin
      rd_reg(HBS_REG_STATUS, d);
      if ((d & m) === v) break;
    end
    check(d & m, v);
  endtask

  // Close inputs, then let host finish recovery and re-energize
  task release_in;
    @(posedge clk);
    in1 <= 1'b1; in2 <= 1'b1;
    wait_flag(1'b0);
  endtask
  task finish_rec(input logic plan);
    wait_st(32'h0000_ff00, 32'h0000_2000);
    rd_reg(HBS_REG_POS, d);
    check(d, pos);
    rd_reg(HBS_REG_CTRL, d);
    check(d[0], 1'b1);
    wr_reg(HBS_REG_CTRL, {30'h0, plan, 1'b1});
    wait_st(32'h0000_0014, 32'h0000_0014);
    check(cur_en, 1'b1);
    check(move_ok, 1'b1);
    rd_reg(HBS_REG_CTRL, d);
    check(d, {30'h0, plan, 1'b0});
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      errors++;
      test_done;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    finish_rec(1'b0);
    // Block with each interrupted command and stop method
    foreach (rows[i]) begin
      meth <= rows[i].meth;
      pos <= 32'h0000_1200 + i;
      if (rows[i].code != HBS_CMD_SERVO_ON) wr_reg(HBS_REG_CMD, {24'h0, rows[i].code});
      repeat (6) @(posedge clk);
      in1 <= !rows[i].opens[0];
      in2 <= !rows[i].opens[1];
      wait_flag(1'b1);
      check(link.cmd_warning, rows[i].warn);
      check({cur_en, blk}, 2'b01);
      check(link.servo_status_word[13:12], 2'b00);
      if (rows[i].code != HBS_CMD_SERVO_OFF) check(brake, rows[i].meth <= 4'h1);
      repeat (12) @(posedge clk);
      check(link.cmd_warning, 1'b0);
      check(move_ok, 1'b0);
      if (rows[i].code != HBS_CMD_SERVO_OFF) check(brake, rows[i].meth == 4'h0);
      if (rows[i].opens == 2'b11) begin
        in1 <= 1'b1;
        repeat (10) @(posedge clk);
        check({blk, link.servo_io_monitor_word[HBS_IO_BLOCK_BIT]}, 2'b11);
      end
      release_in;
      finish_rec(1'b0);
    end
    // Interrupt masking, refusal while blocked, clear by writing one
    wr_reg(HBS_REG_IRQ_ST, 32'h0000_001f);
    wr_reg(HBS_REG_IRQ_MK, 32'h0);
    in2 <= 1'b0;
    wait_flag(1'b1);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    wr_reg(HBS_REG_IRQ_MK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    wr_reg(HBS_REG_CMD, {24'h0, HBS_CMD_SERVO_ON});
    rd_reg(HBS_REG_IRQ_ST, d);
    check(d[HBS_IRQ_REFUSED], 1'b1);
    check(link.servo_status_word[HBS_ST_SVON_BIT], 1'b0);
    wr_reg(HBS_REG_IRQ_ST, 32'h0000_001f);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    rd_reg(8'h20, d);
    check(d, 32'h0);
    // Release with main power down: host must wait for power ready
    pwr <= 1'b0;
    release_in;
    repeat (6) @(posedge clk);
    check(link.servo_status_word[HBS_ST_MRDY_BIT], 1'b0);
    wait_st(32'h0000_ff00, 32'h0000_1000);
    pwr <= 1'b1;
    finish_rec(1'b1);
    // Mid-run reset: reset values, then boot block recovery
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check({cur_en, brake, blk, move_ok, irq}, 5'b00110);
    check(link.servo_io_monitor_word | link.servo_status_word, 32'h0);
    check({link.cmd_valid, link.cmd_warning, link.cmd_code}, {2'b00, HBS_CMD_MONITOR});
    check(rdata, 32'h0);
    rstn <= 1'b1;
    finish_rec(1'b0);
    test_done;
  end
endmodule
